// ---- rtl/exception_pkg.sv ----
// Shared constants of the exception sequencer: vector numbers, vector
// table layout, condition code bit positions and stack framing.
// Assumes a 24-bit address space with the vector table in the low 64 kB.
package exception_pkg;

  localparam int unsigned ADDR_W      = 24;
  localparam int unsigned VEC_W       = 6;
  localparam int unsigned VEC_COUNT   = 64;
  localparam int unsigned NUM_IRQ     = 6;
  localparam int unsigned NUM_INT     = 30;
  localparam int unsigned PRIO_BITS   = 12;
  localparam int unsigned INT_PER_GRP = 3;

  // Vector numbers
  localparam logic [VEC_W-1:0] VEC_RESET     = 6'h00;
  localparam logic [VEC_W-1:0] VEC_NMI       = 6'h07;
  localparam logic [VEC_W-1:0] VEC_TRAP_BASE = 6'h08;
  localparam logic [VEC_W-1:0] VEC_IRQ_BASE  = 6'h0C;
  localparam logic [VEC_W-1:0] VEC_INT_BASE  = 6'h14;
  localparam logic [VEC_W-1:0] VEC_INT_LAST  = 6'h3C;

  // Vector address is the vector number times four, upper bits zero
  localparam logic [7:0]        VEC_ADDR_HI  = 8'h00;
  localparam logic [1:0]        VEC_ADDR_LO  = 2'h0;
  localparam logic [ADDR_W-1:0] WORD_STEP    = 24'h000002;
  localparam logic [ADDR_W-1:0] FRAME_BYTES  = 24'h000004;

  // Condition code bits
  localparam int unsigned CCR_I_BIT  = 7;
  localparam int unsigned CCR_UI_BIT = 6;
  localparam logic [7:0]  CCR_I_MASK  = 8'h80;
  localparam logic [7:0]  CCR_UI_MASK = 8'h40;

  typedef enum logic [2:0] {
    S_RESET,
    S_IDLE,
    S_PUSH_LO,
    S_PUSH_HI,
    S_VEC_HI,
    S_VEC_LO,
    S_CHECK
  } seq_state_e;

endpackage : exception_pkg

// ---- rtl/arb_if.sv ----
// Request vector and winner of one priority level, passed between the
// sequencer and its lowest-index encoder. Purely combinational signals.
`timescale 1ns/1ps
interface arb_if
  import exception_pkg::*;
();
  logic [VEC_COUNT-1:0] req;
  logic                 found;
  logic [VEC_W-1:0]     index;

  modport enc  (input req, output found, output index);
  modport user (output req, input found, input index);
endinterface : arb_if

// ---- rtl/lowest_index_encoder.sv ----
// Finds the lowest set bit of a request vector; the lower vector number
// wins inside one priority level. Pure combinational logic.
`timescale 1ns/1ps
module lowest_index_encoder
  import exception_pkg::*;
(
  // Request vector and result
  arb_if.enc arb
);

  // Scan from the top so the lowest set bit is written last
  always_comb begin
    arb.found = 1'b0;
    arb.index = VEC_RESET;
    for (int i = VEC_COUNT - 1; i >= 0; i--) begin
      if (arb.req[i]) begin
        arb.found = 1'b1;
        arb.index = VEC_W'(i);
      end
    end
  end

endmodule : lowest_index_encoder

// ---- rtl/exception_sequencer.sv ----
// Exception sequencer: ranks reset, interrupt and trap exceptions, saves
// the return context on the stack and loads the start address from the
// vector table. Assumes a core that stalls on core_hold and reports
// instruction boundaries, and a memory port that answers with bus_ack.
//
// Contract
// (RULE1) Reset outranks interrupts, interrupts outrank traps; simultaneous ones run in turn.
// (RULE2) A trap is always accepted while the program runs, never masked.
// (RULE3) Reset handling starts right after the reset pin rises.
// (RULE4) An interrupt waits for the current instruction or exception to finish.
// (RULE5) Trap or interrupt: push PC and CONDITION_CODE_REG, set mask, jump through vector.
// (RULE6) Reset saves nothing; it only sets the mask and jumps through vector.
// (RULE7) Reset start address comes from bytes 0x0000 to 0x0003.
// (RULE8) The four traps use vectors 8 to 11, from address 0x0020.
// (RULE9) NMI uses vector 7; request lines 0 to 5 use vectors 12 to 17.
// (RULE10) Vectors 1-6 and 18-19 unused; internal sources use vectors 20 to 60; the code maps its 30 internal sources onto vectors 20 to 49.
// (RULE11) While the reset pin is low all processing halts and modules reset.
// (RULE12) Reset pin held low 20 ms at power-up, ten clocks in operation.
// (RULE13) Reset handling sets the interrupt mask bit.
// (RULE14) Watchdog overflow causes a reset handled like an external one.
// (RULE15) After reset every interrupt, NMI too, waits for the first instruction.
// (RULE16) Software sets the stack pointer with its first instruction.
// (RULE17) NMI is always accepted and ranks above all other interrupts.
// (RULE18) Maskable sources have two priority levels; simultaneous ones are arbitrated.
// (RULE19) Seven external and thirty internal interrupt sources are accepted.
// (RULE20) Refresh timer compare match arrives as an internal request.
// (RULE21) Trap sets the mask bit; with user bit select clear, also UI.
// (RULE22) Trap vector chosen by a two-bit number from the instruction.
// (RULE23) Vector address is four times the number; a four-byte entry is read.
// (RULE24) Sequencer idles in reset; vector fetch starts the edge after release.
`timescale 1ns/1ps
module exception_sequencer
  import exception_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Reset sources
  input  wire logic                external_reset_pin_n,
  input  wire logic                watchdog_overflow,
  // Interrupt sources and configuration
  input  wire logic                nmi_pin,
  input  wire logic                nmi_rising_edge,
  input  wire logic [NUM_IRQ-1:0]  external_request_lines,
  input  wire logic [NUM_INT-1:0]  internal_requests,
  input  wire logic [7:0]          priority_select_a,
  input  wire logic [7:0]          priority_select_b,
  input  wire logic                user_bit_select,
  // Core status
  input  wire logic                instr_done,
  input  wire logic                trap_instruction,
  input  wire logic [1:0]          trap_number,
  input  wire logic [ADDR_W-1:0]   program_counter,
  input  wire logic [7:0]          condition_code_reg,
  input  wire logic [ADDR_W-1:0]   stack_pointer,
  // Core control
  output logic                     core_hold,
  output logic                     module_reset,
  output logic                     pc_load,
  output logic [ADDR_W-1:0]        pc_value,
  output logic                     sp_load,
  output logic [ADDR_W-1:0]        sp_value,
  output logic                     ccr_write,
  output logic [7:0]               ccr_value,
  // Interrupt acknowledge
  output logic                     int_ack,
  output logic [VEC_W-1:0]         int_ack_vector,
  // Memory port
  output logic                     bus_req,
  output logic                     bus_we,
  output logic [ADDR_W-1:0]        bus_addr,
  output logic [15:0]              bus_wdata,
  input  wire logic                bus_ack,
  input  wire logic [15:0]         bus_rdata
);

  seq_state_e         state_reg, state_next;
  logic [VEC_W-1:0]   vec_reg, vec_next;
  logic               is_reset_reg, is_reset_next;
  logic               set_ui_reg, set_ui_next;
  logic [7:0]         vec_hi_reg, vec_hi_next;
  logic [ADDR_W-1:0]  saved_pc_reg, saved_pc_next;
  logic [7:0]         saved_ccr_reg, saved_ccr_next;
  logic               int_block_reg, int_block_next;
  logic               trap_pending_reg, trap_pending_next;
  logic [1:0]         trap_num_reg, trap_num_next;
  logic               nmi_pending_reg, nmi_pending_next;
  logic               nmi_prev_reg;
  logic               rst_pin_prev_reg;
  logic               wdt_reset_reg, wdt_reset_next;
  logic               core_hold_reg, core_hold_next;
  logic               module_reset_reg, module_reset_next;
  logic               pc_load_reg, pc_load_next;
  logic [ADDR_W-1:0]  pc_value_reg, pc_value_next;
  logic               sp_load_reg, sp_load_next;
  logic [ADDR_W-1:0]  sp_value_reg, sp_value_next;
  logic               ccr_write_reg, ccr_write_next;
  logic [7:0]         ccr_value_reg, ccr_value_next;
  logic               int_ack_reg, int_ack_next;
  logic [VEC_W-1:0]   int_ack_vector_reg, int_ack_vector_next;
  logic               bus_req_reg, bus_req_next;
  logic               bus_we_reg, bus_we_next;
  logic [ADDR_W-1:0]  bus_addr_reg, bus_addr_next;
  logic [15:0]        bus_wdata_reg, bus_wdata_next;

  // Source mapping onto vector numbers; unused vectors stay zero
  logic [VEC_COUNT-1:0] level1_req;
  logic [VEC_COUNT-1:0] level0_req;
  logic [PRIO_BITS-1:0] int_prio;
  logic [NUM_IRQ-1:0]   irq_prio;

  assign irq_prio = {priority_select_a[4], priority_select_a[4],
                     priority_select_a[5], priority_select_a[5],
                     priority_select_a[6], priority_select_a[7]};   // [RULE18]
  assign int_prio = {priority_select_a[3:0], priority_select_b};

  // Request lines go to vectors 12..17, internal sources from 20 upward
  always_comb begin
    level1_req = '0;
    level0_req = '0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      level1_req[VEC_IRQ_BASE + i] = external_request_lines[i] & irq_prio[i];   // [RULE9]
      level0_req[VEC_IRQ_BASE + i] = external_request_lines[i] & ~irq_prio[i];
    end
    for (int i = 0; i < NUM_INT; i++) begin
      level1_req[VEC_INT_BASE + i] = internal_requests[i]
                                     & int_prio[PRIO_BITS - 1 - i / INT_PER_GRP];   // [RULE10]
      level0_req[VEC_INT_BASE + i] = internal_requests[i]
                                     & ~int_prio[PRIO_BITS - 1 - i / INT_PER_GRP];  // [RULE19] [RULE20]
    end
  end

  // One encoder per priority level; lower vector number wins a tie
  arb_if arb_hi ();
  arb_if arb_lo ();
  assign arb_hi.req = level1_req;
  assign arb_lo.req = level0_req;

  lowest_index_encoder u_enc_hi (
    .arb (arb_hi.enc)
  );
  lowest_index_encoder u_enc_lo (
    .arb (arb_lo.enc)
  );

  // Masking: I alone blocks all maskable sources when UI is a user bit,
  // otherwise I blocks level 0 and I with UI blocks both levels
  wire mask_i     = condition_code_reg[CCR_I_BIT];
  wire mask_ui    = condition_code_reg[CCR_UI_BIT];
  wire accept_l1  = ~mask_i | (~user_bit_select & ~mask_ui);
  wire accept_l0  = ~mask_i;
  wire take_l1    = arb_hi.found & accept_l1;                       // [RULE18]
  wire take_l0    = arb_lo.found & accept_l0;
  wire take_nmi   = nmi_pending_reg;                                // [RULE17]
  wire int_ready  = ~int_block_reg & (take_nmi | take_l1 | take_l0); // [RULE15]
  wire [VEC_W-1:0] int_vec = take_nmi ? VEC_NMI :
                             take_l1  ? arb_hi.index : arb_lo.index;

  // NMI edge detection on the selected edge
  wire nmi_edge = nmi_rising_edge ? (nmi_pin & ~nmi_prev_reg) : (~nmi_pin & nmi_prev_reg);

  // Reset pin handling
  wire pin_low     = ~external_reset_pin_n;
  wire pin_release = external_reset_pin_n & (~rst_pin_prev_reg | wdt_reset_reg); // [RULE3]

  // Trap vector 8..11 and address of the chosen vector entry
  wire [VEC_W-1:0]  trap_vec  = VEC_TRAP_BASE + VEC_W'(trap_num_reg);          // [RULE22]
  wire [ADDR_W-1:0] vec_addr  = {VEC_ADDR_HI, 8'h00, vec_reg, VEC_ADDR_LO};   // [RULE23]
  wire [ADDR_W-1:0] push_lo_a = stack_pointer - WORD_STEP;
  wire [ADDR_W-1:0] push_hi_a = stack_pointer - FRAME_BYTES;

  // Sequencer next state and registered outputs
  always_comb begin
    state_next          = state_reg;
    vec_next            = vec_reg;
    is_reset_next       = is_reset_reg;
    set_ui_next         = set_ui_reg;
    vec_hi_next         = vec_hi_reg;
    saved_pc_next       = saved_pc_reg;
    saved_ccr_next      = saved_ccr_reg;
    int_block_next      = int_block_reg;
    wdt_reset_next      = wdt_reset_reg;
    core_hold_next      = core_hold_reg;
    module_reset_next   = 1'b0;
    pc_load_next        = 1'b0;
    pc_value_next       = pc_value_reg;
    sp_load_next        = 1'b0;
    sp_value_next       = sp_value_reg;
    ccr_write_next      = 1'b0;
    ccr_value_next      = ccr_value_reg;
    int_ack_next        = 1'b0;
    int_ack_vector_next = int_ack_vector_reg;
    bus_req_next        = bus_req_reg;
    bus_we_next         = bus_we_reg;
    bus_addr_next       = bus_addr_reg;
    bus_wdata_next      = bus_wdata_reg;
    // Trap latched until serviced; a new trap wins over the clear
    trap_pending_next   = trap_pending_reg;
    trap_num_next       = trap_num_reg;
    nmi_pending_next    = nmi_pending_reg;

    case (state_reg)
      // Halted; leave on the pin's rising edge or after a watchdog reset
      S_RESET: begin
        core_hold_next    = 1'b1;
        module_reset_next = pin_low;                                  // [RULE11]
        if (pin_release) begin
          state_next       = S_VEC_HI;                                // [RULE24]
          vec_next         = VEC_RESET;                               // [RULE7]
          is_reset_next    = 1'b1;                                    // [RULE6]
          set_ui_next      = 1'b0;
          wdt_reset_next   = 1'b0;
          int_block_next   = 1'b1;                                    // [RULE15]
          bus_req_next     = 1'b1;
          bus_we_next      = 1'b0;
          bus_addr_next    = {VEC_ADDR_HI, 8'h00, VEC_RESET, VEC_ADDR_LO};
        end
      end
      // Program runs, or an exception has just ended (S_CHECK); decisions at an instruction boundary or in S_CHECK
      S_IDLE, S_CHECK: begin
        if (state_reg == S_IDLE && instr_done) begin
          int_block_next = 1'b0;                                      // [RULE15]
        end
        if (state_reg == S_CHECK || instr_done) begin                 // [RULE4]
          if (int_ready) begin                                        // [RULE1]
            state_next          = S_PUSH_LO;
            vec_next            = int_vec;
            set_ui_next         = 1'b0;
            int_ack_next        = 1'b1;
            int_ack_vector_next = int_vec;
            if (take_nmi) begin
              nmi_pending_next = 1'b0;
            end
          end else if (trap_pending_reg || (instr_done && trap_instruction)) begin // [RULE2]
            state_next        = S_PUSH_LO;
            vec_next          = trap_pending_reg ? trap_vec
                                : VEC_TRAP_BASE + VEC_W'(trap_number);  // [RULE8]
            set_ui_next       = ~user_bit_select;                     // [RULE21]
            trap_pending_next = 1'b0;
          end else begin
            state_next     = S_IDLE;
            core_hold_next = 1'b0;
          end
          if (state_next == S_PUSH_LO) begin
            is_reset_next  = 1'b0;
            core_hold_next = 1'b1;
            saved_pc_next  = program_counter;
            saved_ccr_next = condition_code_reg;
            bus_req_next   = 1'b1;
            bus_we_next    = 1'b1;
            bus_addr_next  = push_lo_a;                               // [RULE5]
            bus_wdata_next = program_counter[15:0];
          end
        end
      end
      // Low half of the return address has been pushed
      S_PUSH_LO: begin
        if (bus_ack) begin
          state_next     = S_PUSH_HI;
          bus_addr_next  = push_hi_a;
          bus_wdata_next = {saved_ccr_reg, saved_pc_reg[ADDR_W-1:16]};  // [RULE5]
        end
      end
      // Condition codes and high address byte pushed; read the vector
      S_PUSH_HI: begin
        if (bus_ack) begin
          state_next    = S_VEC_HI;
          bus_we_next   = 1'b0;
          bus_addr_next = vec_addr;
        end
      end
      S_VEC_HI: begin
        if (bus_ack) begin
          state_next    = S_VEC_LO;
          vec_hi_next   = bus_rdata[7:0];
          bus_addr_next = bus_addr_reg + WORD_STEP;                   // [RULE23]
        end
      end
      // Entry complete: load PC, mask bits and, except after reset, the new stack pointer
      S_VEC_LO: begin
        if (bus_ack) begin
          bus_req_next   = 1'b0;
          pc_load_next   = 1'b1;
          pc_value_next  = {vec_hi_reg, bus_rdata};
          ccr_write_next = 1'b1;
          ccr_value_next = condition_code_reg | CCR_I_MASK
                           | (set_ui_reg ? CCR_UI_MASK : 8'h00);      // [RULE13]
          sp_load_next   = ~is_reset_reg;                             // [RULE6]
          sp_value_next  = push_hi_a;
          if (is_reset_reg) begin
            // First instruction always runs before any interrupt
            state_next     = S_IDLE;
            core_hold_next = 1'b0;
          end else begin
            state_next     = S_CHECK;
          end
        end
      end
      default: begin
        state_next = S_RESET;
      end
    endcase

    // Reset sources override anything in progress
    if (pin_low || watchdog_overflow) begin                          // [RULE14]
      state_next        = S_RESET;
      core_hold_next    = 1'b1;
      module_reset_next = 1'b1;                                       // [RULE11]
      bus_req_next      = 1'b0;
      trap_pending_next = 1'b0;
      nmi_pending_next  = 1'b0;
      wdt_reset_next    = watchdog_overflow | (wdt_reset_reg & ~pin_low);
    end else begin
      if (trap_instruction && instr_done && state_reg == S_IDLE && int_ready) begin
        trap_pending_next = 1'b1;                                     // [RULE1]
        trap_num_next     = trap_number;
      end
      if (nmi_edge) begin
        nmi_pending_next = 1'b1;                                      // [RULE17]
      end
    end
  end

  // Sequencer state and context
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg        <= S_RESET;
      vec_reg          <= VEC_RESET;
      is_reset_reg     <= 1'b1;
      set_ui_reg       <= 1'b0;
      vec_hi_reg       <= 8'h00;
      saved_pc_reg     <= '0;
      saved_ccr_reg    <= 8'h00;
      int_block_reg    <= 1'b1;
      trap_pending_reg <= 1'b0;
      trap_num_reg     <= 2'h0;
      nmi_pending_reg  <= 1'b0;
      nmi_prev_reg     <= 1'b0;
      rst_pin_prev_reg <= 1'b0;  // Pin already high at release counts as a rise
      wdt_reset_reg    <= 1'b0;
    end else begin
      state_reg        <= state_next;
      vec_reg          <= vec_next;
      is_reset_reg     <= is_reset_next;
      set_ui_reg       <= set_ui_next;
      vec_hi_reg       <= vec_hi_next;
      saved_pc_reg     <= saved_pc_next;
      saved_ccr_reg    <= saved_ccr_next;
      int_block_reg    <= int_block_next;
      trap_pending_reg <= trap_pending_next;
      trap_num_reg     <= trap_num_next;
      nmi_pending_reg  <= nmi_pending_next;
      nmi_prev_reg     <= nmi_pin;
      rst_pin_prev_reg <= external_reset_pin_n;
      wdt_reset_reg    <= wdt_reset_next;
    end
  end

  // Output registers
  always_ff @(posedge clk) begin
    if (rst) begin
      core_hold_reg      <= 1'b1;
      module_reset_reg   <= 1'b1;
      pc_load_reg        <= 1'b0;
      pc_value_reg       <= '0;
      sp_load_reg        <= 1'b0;
      sp_value_reg       <= '0;
      ccr_write_reg      <= 1'b0;
      ccr_value_reg      <= CCR_I_MASK;
      int_ack_reg        <= 1'b0;
      int_ack_vector_reg <= VEC_RESET;
      bus_req_reg        <= 1'b0;
      bus_we_reg         <= 1'b0;
      bus_addr_reg       <= '0;
      bus_wdata_reg      <= 16'h0000;
    end else begin
      core_hold_reg      <= core_hold_next;
      module_reset_reg   <= module_reset_next;
      pc_load_reg        <= pc_load_next;
      pc_value_reg       <= pc_value_next;
      sp_load_reg        <= sp_load_next;
      sp_value_reg       <= sp_value_next;
      ccr_write_reg      <= ccr_write_next;
      ccr_value_reg      <= ccr_value_next;
      int_ack_reg        <= int_ack_next;
      int_ack_vector_reg <= int_ack_vector_next;
      bus_req_reg        <= bus_req_next;
      bus_we_reg         <= bus_we_next;
      bus_addr_reg       <= bus_addr_next;
      bus_wdata_reg      <= bus_wdata_next;
    end
  end

  assign core_hold      = core_hold_reg;
  assign module_reset   = module_reset_reg;
  assign pc_load        = pc_load_reg;
  assign pc_value       = pc_value_reg;
  assign sp_load        = sp_load_reg;
  assign sp_value       = sp_value_reg;
  assign ccr_write      = ccr_write_reg;
  assign ccr_value      = ccr_value_reg;
  assign int_ack        = int_ack_reg;
  assign int_ack_vector = int_ack_vector_reg;
  assign bus_req        = bus_req_reg;
  assign bus_we         = bus_we_reg;
  assign bus_addr       = bus_addr_reg;
  assign bus_wdata      = bus_wdata_reg;

endmodule : exception_sequencer

// ---- dv/exc_seq_chk.sv ----
// Port checks of the exception sequencer.
// Assumes one clock domain, synchronous active-high rst.
`timescale 1ns/1ps
module exc_seq_chk
  import exception_pkg::*;
(
  // Clock, reset, sources
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              external_reset_pin_n,
  input wire logic              watchdog_overflow,
  input wire logic [ADDR_W-1:0] stack_pointer,
  // Sequencer outputs
  input wire logic              core_hold,
  input wire logic              module_reset,
  input wire logic              sp_load,
  input wire logic [ADDR_W-1:0] sp_value,
  input wire logic              ccr_write,
  input wire logic [7:0]        ccr_value,
  input wire logic              int_ack,
  input wire logic [VEC_W-1:0]  int_ack_vector,
  input wire logic              bus_req,
  input wire logic              bus_we,
  input wire logic [ADDR_W-1:0] bus_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // First reset and push steps
  sequence s_fetch0; bus_req && !bus_we && bus_addr == 24'h000000; endsequence
  sequence s_push; bus_req && bus_we && bus_addr == stack_pointer - WORD_STEP; endsequence
  a_reset_fetch_start: assert property ($rose(external_reset_pin_n) |=> s_fetch0)
    else $error("reset fetch did not start");
  a_pin_low_halt: assert property (!external_reset_pin_n |=> core_hold && module_reset)
    else $error("no halt while reset pin low");
  a_reset_no_save: assert property ($rose(external_reset_pin_n) |=> (!bus_we && !sp_load)[*4])
    else $error("reset saved context");
  a_reset_blocks_int: assert property ($rose(external_reset_pin_n) |=> !int_ack [*8])
    else $error("int after reset");
  a_mask_set: assert property (ccr_write |-> ccr_value[CCR_I_BIT])
    else $error("mask bit not set");
  a_ack_vec_legal: assert property (int_ack |-> int_ack_vector == VEC_NMI
    || (int_ack_vector inside {[12:17]}) || (int_ack_vector inside {[20:60]}))
    else $error("illegal interrupt vector");
  a_sp_frame: assert property (sp_load |-> sp_value == stack_pointer - FRAME_BYTES)
    else $error("stack frame size wrong");
  a_push_first: assert property (int_ack |-> s_push)
    else $error("push did not start with ack");
  a_vec_addr_low: assert property (bus_req && !bus_we |-> bus_addr[23:8] == 16'h0000
    && !bus_addr[0])
    else $error("vector read outside table");
  a_watchdog_reset: assert property (watchdog_overflow |=> module_reset && core_hold)
    else $error("watchdog did not reset");
endmodule : exc_seq_chk

bind exception_sequencer exc_seq_chk chk_u (.*);

// ---- dv/vec_mem_model.sv ----
// Memory behind the sequencer bus: table word at a is {~a[7:0], a[7:0]}.
// Latency from the bench; idle data is inverted.
`timescale 1ns/1ps
module vec_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Bus port
  input  wire logic        bus_req,
  input  wire logic        bus_we,
  input  wire logic [23:0] bus_addr,
  output logic             bus_ack,
  output logic [15:0]      bus_rdata,
  // Answer latency
  input  wire logic [3:0]  lat
);
  logic [3:0] wait_reg;
  // One-cycle ack per request
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_ack   <= 1'b0;
      wait_reg  <= 4'h0;
      bus_rdata <= 16'h0000;
    end else if (bus_ack || !bus_req) begin
      bus_ack   <= 1'b0;
      wait_reg  <= 4'h0;
      bus_rdata <= ~bus_rdata;
    end else if (wait_reg >= lat) begin
      bus_ack   <= 1'b1;
      bus_rdata <= bus_we ? ~bus_rdata : {~bus_addr[7:0], bus_addr[7:0]};
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule : vec_mem_model

// ---- dv/tb_top.sv ----
// Self-checking bench of the exception sequencer.
// Bench plays core, reset source and interrupt controller.
`timescale 1ns/1ps
module tb_top
  import exception_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, external_reset_pin_n = 1'b0, watchdog_overflow = 1'b0;
  logic nmi_pin = 1'b0, nmi_rising_edge = 1'b1, user_bit_select = 1'b0, instr_done = 1'b0;
  logic [5:0] external_request_lines = 6'h00;
  logic [29:0] internal_requests = 30'h0;
  logic [7:0] priority_select_a = 8'h00, priority_select_b = 8'h00, condition_code_reg = 8'h00;
  logic trap_instruction = 1'b0, bus_ack, core_hold, module_reset, pc_load, sp_load, ccr_write;
  logic [1:0] trap_number = 2'h0;
  logic [23:0] program_counter = 24'h001234, stack_pointer = 24'h00FF00;
  logic [23:0] pc_value, sp_value, bus_addr;
  logic [15:0] bus_rdata, bus_wdata;
  logic [7:0] ccr_value;
  logic [5:0] int_ack_vector;
  logic [3:0] lat = 4'h0;
  logic int_ack, bus_req, bus_we;
  int miscompares = 0, n_compared = 0, cycles = 0;

  exception_sequencer dut_u (.*);
  vec_mem_model mem_u (.*);

  // Core keeps the condition codes the sequencer writes
  always @(posedge clk) if (ccr_write) condition_code_reg <= ccr_value;

  // 40 MHz clock and cycle ceiling
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [23:0] seen, input logic [23:0] want, input string what);
    n_compared++;
    if (seen !== want) begin
      miscompares++;
      $display("[FAIL] %0t %s saw %h want %h", $time, what, seen, want);
    end
  endtask : check

  // Start address the model yields for vector v
  function automatic logic [23:0] exp_pc(input logic [5:0] v);
    logic [7:0] a;
    a = {v, 2'b00};
    return {a, ~(a + 8'h02), a + 8'h02};
  endfunction : exp_pc

  // One instruction boundary while the core runs; return clears the mask
  task automatic step(input logic trap, input logic [1:0] num);
    while (core_hold !== 1'b0) @(negedge clk);
    @(posedge clk);
    condition_code_reg <= 8'h00;
    instr_done <= 1'b1;
    trap_instruction <= trap;
    trap_number <= num;
    @(posedge clk);
    instr_done <= 1'b0;
    trap_instruction <= 1'b0;
    @(negedge clk);
  endtask : step

  // Kind 0 reset, 1 interrupt, 2 trap
  task automatic expect_exc(input logic [5:0] v, input int kind);
    int n;
    n = 0;
    while (kind == 1 && int_ack !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (kind == 1) check(int_ack_vector, v, "vector");
    while (pc_load !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check(pc_value, exp_pc(v), "start");
    check(sp_load, kind != 0, "push");
    check(ccr_value, kind == 2 ? 8'hC0 : 8'h80, "mask");
    @(negedge clk);
  endtask : expect_exc

  task automatic t_reset;
    repeat (12) @(posedge clk);
    @(negedge clk);
    check(core_hold && module_reset, 1'b1, "halt");
    @(posedge clk);
    external_reset_pin_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check(bus_req, 1'b1, "fetch");
    expect_exc(VEC_RESET, 0);
    step(1'b0, 2'h0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_nmi_trap;
    lat <= 4'h3;
    nmi_pin <= 1'b1;
    step(1'b1, 2'h2);
    expect_exc(VEC_NMI, 1);
    expect_exc(6'd10, 2);
    for (int i = 0; i < 4; i++) begin
      step(1'b1, i[1:0]);
      expect_exc(VEC_TRAP_BASE + 6'(i), 2);
    end
    $display("nmi and trap test done");
  endtask : t_nmi_trap

  task automatic t_levels;
    user_bit_select <= 1'b1;
    priority_select_a <= 8'h10;
    priority_select_b <= 8'h04;
    external_request_lines <= 6'h11;
    internal_requests <= 30'h20000000;
    step(1'b0, 2'h0);
    expect_exc(6'd16, 1);
    external_request_lines <= 6'h01;
    step(1'b0, 2'h0);
    expect_exc(6'd49, 1);
    internal_requests <= 30'h0;
    step(1'b0, 2'h0);
    expect_exc(6'd12, 1);
    external_request_lines <= 6'h00;
    $display("level test done");
  endtask : t_levels

  task automatic t_watchdog;
    lat <= 4'h5;
    step(1'b1, 2'h3);
    repeat (3) @(posedge clk);
    watchdog_overflow <= 1'b1;
    @(posedge clk);
    watchdog_overflow <= 1'b0;
    @(negedge clk);
    check(module_reset, 1'b1, "watchdog reset");
    expect_exc(VEC_RESET, 0);
    $display("watchdog test done");
  endtask : t_watchdog

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_nmi_trap();
    t_levels();
    t_watchdog();
    tally_and_finish();
  end
endmodule : tb_top
